/* File: rtl/ssp_pin_if.sv */
`default_nettype none
interface ssp_pin_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_n;
  logic sdio;
  logic ce;
  modport src (output sclk_rise, output sclk_fall, output sel_n, output sdio, output ce);
  modport dst (input sclk_rise, input sclk_fall, input sel_n, input sdio, input ce);
endinterface
`default_nettype wire

/* File: rtl/ssp_pkg.sv */
`default_nettype none
package ssp_pkg;
  // ----------------------------------------
  // Framing
  // ----------------------------------------
  localparam int unsigned CMD_BITS   = 16;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned CNT_BITS   = 5;
  localparam logic [4:0]  CMD_LAST   = 5'h0F;
  localparam logic [4:0]  DATA_FIRST = 5'h10;
  localparam logic [4:0]  FRAME_LAST = 5'h17;
  localparam logic [4:0]  FRAME_END  = 5'h18;
  localparam int unsigned READ_POS   = 15;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  localparam int unsigned REG_COUNT  = 16;
  localparam int unsigned IDX_BITS   = 4;
  localparam logic [3:0]  MODE_REG   = 4'h0;
  localparam int unsigned MODE_POS   = 4;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [4:0]  CNT_RESET  = 5'h00;
endpackage
`default_nettype wire

/* File: rtl/ssp_port.sv */
// What this block does
// - Input data bits are captured on the rising edge of the serial clock, where the host holds them valid.
// - While the data pin is an input, incoming bits are taken from that pin.
// - In 3-wire mode, the default after reset, read data is driven on the two-way data pin.
// - In 3-wire mode the separate output pin is never driven.
// - In 4-wire mode read data appears on the separate output pin during a read burst.
// - Deasserting the select returns the separate output pin to high impedance.
// - Chip enable low returns every register to its reset value; high enables the port.
`default_nettype none
module ssp_port (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic chip_enable,
  input  wire logic serial_select_n,
  input  wire logic serial_clk,
  input  wire logic sdio_in,
  output var  logic sdio_out,
  output var  logic sdio_oe,
  output var  logic serial_data_out,
  output var  logic serial_data_out_oe,
  output var  logic four_wire_mode
);
  ssp_pin_if pins ();

  ssp_sync u_sync (
    .clk             (clk),
    .rst             (rst),
    .chip_enable     (chip_enable),
    .serial_select_n (serial_select_n),
    .serial_clk      (serial_clk),
    .sdio_in         (sdio_in),
    .pins            (pins.src)
  );

  // ----------------------------------------
  // Burst tracking
  // ----------------------------------------
  logic [ssp_pkg::CNT_BITS-1:0]  bit_cnt;
  logic [ssp_pkg::CMD_BITS-1:0]  cmd;
  logic [ssp_pkg::CMD_BITS-1:0]  cmd_shift;
  logic [ssp_pkg::DATA_BITS-1:0] data_shift;
  logic [ssp_pkg::DATA_BITS-1:0] rd_shift;
  logic [ssp_pkg::DATA_BITS-1:0] regs [ssp_pkg::REG_COUNT];
  logic                          reading;
  logic                          active;
  logic                          write_hit;
  logic [ssp_pkg::IDX_BITS-1:0]  idx;
  logic [ssp_pkg::DATA_BITS-1:0] wr_data;
  logic                          rise_hit;
  logic                          fall_hit;
  logic                          cmd_done;
  logic                          load_rd;
  logic                          shift_rd;
  logic [ssp_pkg::DATA_BITS-1:0] rd_word;
  logic [ssp_pkg::REG_COUNT-1:0] reg_wr;

  // ----------------------------------------
  // Edge strobes, qualified by the burst
  // ----------------------------------------
  // burst framed by select
  // Chip enable low also aborts a burst in flight
  assign active    = ~pins.sel_n & pins.ce;
  assign rise_hit  = active & pins.sclk_rise;
  assign fall_hit  = active & pins.sclk_fall;
  assign idx       = cmd[ssp_pkg::IDX_BITS-1:0];
  // data from the pin
  // The last data bit comes straight from the pin stage, so a write lands on the 24th rise
  assign wr_data   = {data_shift[ssp_pkg::DATA_BITS-2:0], pins.sdio};
  assign cmd_done  = rise_hit & (bit_cnt == ssp_pkg::CMD_LAST);
  assign write_hit = rise_hit & (bit_cnt == ssp_pkg::FRAME_LAST) & ~cmd[ssp_pkg::READ_POS];

  // Counter saturates so extra clocks in a burst do nothing
  // It restarts on every deselect, so a cut burst never commits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= ssp_pkg::CNT_RESET;
    end else if (!active) begin
      bit_cnt <= ssp_pkg::CNT_RESET;
    end else if (rise_hit && bit_cnt != ssp_pkg::FRAME_END) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_shift  <= 16'h0000;
      data_shift <= ssp_pkg::REG_RESET;
    end else if (rise_hit) begin
      cmd_shift  <= {cmd_shift[ssp_pkg::CMD_BITS-2:0], pins.sdio};
      data_shift <= wr_data;
    end
  end

  // Command is frozen at its 16th bit so data bits cannot move the index
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd <= 16'h0000;
    end else if (cmd_done) begin
      cmd <= {cmd_shift[ssp_pkg::CMD_BITS-2:0], pins.sdio};
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  for (genvar i = 0; i < ssp_pkg::REG_COUNT; i++) begin : g_reg
    // One write strobe per entry, decoded from the frozen index
    assign reg_wr[i] = write_hit & (idx == ssp_pkg::IDX_BITS'(i));
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        regs[i] <= ssp_pkg::REG_RESET;
      // chip enable clears
      // Clear wins; a write cannot land then anyway, as the burst is aborted
      end else if (!pins.ce) begin
        regs[i] <= ssp_pkg::REG_RESET;
      end else if (reg_wr[i]) begin
        regs[i] <= wr_data;
      end
    end
  end

  // ----------------------------------------
  // Mode
  // ----------------------------------------
  // Mode bit reset value of zero means 3-wire
  // Written like any entry; no other bit of the entry has a meaning here
  assign four_wire_mode = regs[ssp_pkg::MODE_REG][ssp_pkg::MODE_POS];

  // ----------------------------------------
  // Read data phase
  // ----------------------------------------
  // Index is settled from the 16th rise on, so the word needs no hold flop
  assign rd_word  = regs[idx];
  // first bit after the falling edge
  assign load_rd  = fall_hit & (bit_cnt == ssp_pkg::DATA_FIRST) & cmd[ssp_pkg::READ_POS];
  assign shift_rd = fall_hit & reading & ~load_rd;

  // Read flag lives for the data phase of one read burst only
  // It also gates the shifting, so write bursts never touch the data pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reading <= 1'b0;
    end else if (!active) begin
      reading <= 1'b0;
    end else if (load_rd) begin
      reading <= 1'b1;
    end
  end

  // A host that over-clocks a read simply sees trailing zeros
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_shift <= ssp_pkg::REG_RESET;
    end else if (load_rd) begin
      rd_shift <= {rd_word[ssp_pkg::DATA_BITS-2:0], 1'b0};
    end else if (shift_rd) begin
      rd_shift <= {rd_shift[ssp_pkg::DATA_BITS-2:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Read data pins
  // ----------------------------------------
  // Both pins carry the same bit; only their enables tell them apart
  // read data on sdio
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdio_out <= 1'b0;
    end else if (load_rd) begin
      sdio_out <= rd_word[ssp_pkg::DATA_BITS-1];
    end else if (shift_rd) begin
      sdio_out <= rd_shift[ssp_pkg::DATA_BITS-1];
    end
  end

  // read data on output pin
  // The pin keeps its last bit between bursts; only the enable matters then
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_data_out <= 1'b0;
    end else if (load_rd) begin
      serial_data_out <= rd_word[ssp_pkg::DATA_BITS-1];
    end else if (shift_rd) begin
      serial_data_out <= rd_shift[ssp_pkg::DATA_BITS-1];
    end
  end

  // ----------------------------------------
  // Output enables
  // ----------------------------------------
  // Enables drop only once the deselect or chip enable low is seen through the synchroniser,
  // which keeps the release path to one plain condition
  // sdio driven in 3-wire
  // A 4-wire read leaves the two-way pin to the host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdio_oe <= 1'b0;
    end else if (!active) begin
      sdio_oe <= 1'b0;
    end else if (load_rd) begin
      sdio_oe <= ~four_wire_mode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_data_out_oe <= 1'b0;
    end else if (!active) begin
      serial_data_out_oe <= 1'b0;
    end else if (!four_wire_mode) begin
      serial_data_out_oe <= 1'b0;
    end else if (load_rd) begin
      serial_data_out_oe <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ssp_sync.sv */
`default_nettype none
module ssp_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic chip_enable,
  input  wire logic serial_select_n,
  input  wire logic serial_clk,
  input  wire logic sdio_in,
  ssp_pin_if.src    pins
);
  // ----------------------------------------
  // Two-stage synchronisers, then edge finder
  // ----------------------------------------
  logic [3:0] meta;
  logic [3:0] stable;
  logic       sclk_prev;

  // Select resets high so an idle pin never opens a burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta      <= 4'h4;
      stable    <= 4'h4;
      sclk_prev <= 1'b0;
    end else begin
      meta      <= {serial_clk, serial_select_n, sdio_in, chip_enable};
      stable    <= meta;
      sclk_prev <= stable[3];
    end
  end

  assign pins.ce        = stable[0];
  assign pins.sdio      = stable[1];
  assign pins.sel_n     = stable[2];
  assign pins.sclk_rise = stable[3] & ~sclk_prev;
  assign pins.sclk_fall = ~stable[3] & sclk_prev;
endmodule
`default_nettype wire

/* File: testbench/ssp_host.sv */
`default_nettype none
module ssp_host (
  input  wire logic clk,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe,
  output var  logic serial_select_n,
  output var  logic serial_clk,
  output var  logic sdio_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;
  logic last = 1'b0;
  initial serial_select_n = 1'b1;
  initial serial_clk = 1'b0;
  // Released pin shows the inverse of the last bit, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : (drv ? last : ~last);
  task automatic xfer(input logic [23:0] f, input logic four, output logic [7:0] rd, input int n = 24);
    serial_select_n = 1'b0;
    for (int i = 23; i >= 24 - n; i--) begin
      drv = !(f[23] && i < 8);
      if (drv) last = f[i];
      repeat (4) @(negedge clk);
      serial_clk = 1'b1;
      if (i < 8) rd[i] = four ? (serial_data_out_oe ? serial_data_out : 1'bx) : (sdio_oe ? sdio_out : 1'bx);
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
    end
    drv = 1'b0;
    serial_select_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/ssp_port_sva.sv */
`default_nettype none
module ssp_port_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_enable,
  input wire logic serial_select_n,
  input wire logic serial_clk,
  input wire logic sdio_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic four_wire_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic oe = sdio_oe | serial_data_out_oe;
  sequence s_idle; serial_select_n [*6]; endsequence
  sequence s_off; !chip_enable [*5]; endsequence
  property p_sdio; $rose(sdio_oe) |-> !four_wire_mode && !serial_select_n; endproperty
  property p_sdo3; !four_wire_mode |-> !serial_data_out_oe; endproperty
  property p_sdo4; $rose(serial_data_out_oe) |-> four_wire_mode && !sdio_oe; endproperty
  property p_rel; s_idle |-> !oe; endproperty
  property p_clr; s_off |-> !four_wire_mode && !oe; endproperty
  property p_chg; $changed(serial_data_out) && oe && $past(oe) |-> !$past(serial_clk); endproperty
  property p_rise; $rose(four_wire_mode) |-> $past(serial_clk, 2) && !$past(serial_select_n, 2); endproperty
  property p_drop; $fell(four_wire_mode) |-> !chip_enable || !serial_select_n; endproperty
  a_sdio: assert property (p_sdio) else $error("sdio oe");
  a_sdo3: assert property (p_sdo3) else $error("sdo oe 3w");
  a_sdo4: assert property (p_sdo4) else $error("sdo oe 4w");
  a_rel: assert property (p_rel) else $error("oe after select");
  a_clr: assert property (p_clr) else $error("ce clear");
  a_chg: assert property (p_chg) else $error("data edge");
  a_rise: assert property (p_rise) else $error("capture edge");
  a_drop: assert property (p_drop) else $error("mode drop");
endmodule
bind ssp_port ssp_port_chk chk (.clk, .rst, .chip_enable, .serial_select_n, .serial_clk, .sdio_oe,
  .serial_data_out, .serial_data_out_oe, .four_wire_mode);
`default_nettype wire

/* File: testbench/test_ssp_port.sv */
`default_nettype none
module test_ssp_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, chip_enable, serial_select_n, serial_clk, sdio_in, four;
  logic sdio_out, sdio_oe, serial_data_out, serial_data_out_oe, four_wire_mode;
  logic [7:0] mem [16];
  logic [7:0] rd;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  ssp_port uut (.clk, .rst, .chip_enable, .serial_select_n, .serial_clk, .sdio_in, .sdio_out, .sdio_oe,
    .serial_data_out, .serial_data_out_oe, .four_wire_mode);
  ssp_host host (.clk, .sdio_out, .sdio_oe, .serial_data_out, .serial_data_out_oe, .serial_select_n,
    .serial_clk, .sdio_in);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [7:0] want_mode(input logic [7:0] r0);
    return {7'h00, r0[ssp_pkg::MODE_POS]};
  endfunction
  task automatic rd_all();
    for (int i = 0; i < 16; i++) begin
      host.xfer({1'b1, 11'($urandom), 4'(i), 8'h00}, four, rd);
      check(rd, mem[i]);
    end
  endtask
  initial begin
    void'($urandom(86040));
    rst = 1'b1;
    chip_enable = 1'b1;
    four = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check({7'h00, four_wire_mode}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'($urandom) & (i == 0 ? 8'hEF : 8'hFF);
      host.xfer({1'b0, 11'($urandom), 4'(i), mem[i]}, four, rd);
    end
    rd_all();
    // Cut write burst must leave the entry as it was
    host.xfer({1'b0, 11'($urandom), 4'h5, ~mem[5]}, four, rd, 20);
    host.xfer({1'b1, 11'h000, 4'h5, 8'h00}, four, rd);
    check(rd, mem[5]);
    mem[0][4] = 1'b1;
    four = 1'b1;
    host.xfer({1'b0, 11'h000, 4'h0, mem[0]}, four, rd);
    check({7'h00, four_wire_mode}, want_mode(mem[0]));
    rd_all();
    check({6'h00, sdio_oe, serial_data_out_oe}, 8'h00);
    chip_enable = 1'b0;
    repeat (6) @(negedge clk);
    chip_enable = 1'b1;
    repeat (4) @(negedge clk);
    mem = '{default: 8'h00};
    check({7'h00, four_wire_mode}, want_mode(mem[0]));
    four = 1'b0;
    rd_all();
    print_verdict();
  end
endmodule
`default_nettype wire
